// ---- verilog/ldc_consts.svh ----
`ifndef LDC_CONSTS_SVH
`define LDC_CONSTS_SVH

// Register offsets on the serial port (7-bit address field)
`define LDC_OFF_TX_CONTROL   7'h00
`define LDC_OFF_FAULT_A      7'h01
`define LDC_OFF_FAULT_B      7'h02
`define LDC_OFF_EQ_SETTING   7'h03
`define LDC_OFF_BIAS_SETTING 7'h04
`define LDC_OFF_BIAS_LIMIT   7'h05
`define LDC_OFF_BIAS_STEP    7'h06
`define LDC_OFF_STATUS       7'h07

// Field positions
`define LDC_TXC_POL          1
`define LDC_TXC_EQ_EN        3
`define LDC_FA_HARD          0
`define LDC_FB_SOFT          0
`define LDC_FB_BIAS_WARN     1
`define LDC_ST_ACTIVITY      0
`define LDC_ST_BIAS_WARN     1
`define LDC_ST_ALARM         2
`define LDC_ST_COLLISION     3
`define LDC_STEP_MSB         4

// Reset values
`define LDC_RST_TX_CONTROL   8'h00
`define LDC_RST_EQ_SETTING   8'h00
`define LDC_RST_BIAS_LIMIT   8'h00
`define LDC_RST_BIAS_STEP    8'h00
`define LDC_RST_BIAS_CODE    9'h000

// Frame and timing counts
`define LDC_HEAD_BITS        4'h8
`define LDC_DATA_BITS        4'h8
`define LDC_ACT_WINDOW       256

`endif

// ---- verilog/ldc_pkg.sv ----
package ldc_pkg;

  // Serial frame state, Gray coded along idle, head, data, done
  typedef enum logic [1:0] {
    LDC_IDLE = 2'b00,
    LDC_HEAD = 2'b01,
    LDC_DATA = 2'b11,
    LDC_DONE = 2'b10
  } ldc_state_type;

  typedef logic [6:0] ldc_addr_type;
  typedef logic [7:0] ldc_byte_type;
  typedef logic [8:0] ldc_code_type;

endpackage

// ---- verilog/ldc_bias_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Bias update request from the register bank and the code it yields
interface ldc_bias_if;
  import ldc_pkg::*;
  logic         load;
  logic         step;
  ldc_byte_type value;
  ldc_byte_type limit;
  ldc_code_type code;
  logic         warn;

  modport ctl  (output load, output step, output value, output limit,
                input code, input warn);
  modport unit (input load, input step, input value, input limit,
                output code, output warn);
endinterface

`default_nettype wire

// ---- verilog/ldc_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a group of pin inputs
module ldc_sync #(
  parameter int          W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // First stage feeds only the second
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q[i] <= INIT[i];
          q[i]      <= INIT[i];
        end else if (ce) begin
          meta_q[i] <= d[i];
          q[i]      <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

// ---- verilog/ldc_bias.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ldc_consts.svh"

// Nine-bit bias code with upper-byte load and signed step
module ldc_bias (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  ldc_bias_if.unit   bif
);
  import ldc_pkg::*;

  logic signed [10:0] sum;
  logic               over;

  // Sign-extended step added to the current code
  always_comb begin
    sum  = $signed({2'b00, bif.code}) +
           $signed({{6{bif.value[`LDC_STEP_MSB]}}, bif.value[`LDC_STEP_MSB:0]});
    over = (sum < 0) || (sum > $signed({3'b000, bif.limit} <<< 1) + 11'sd1);
  end

  // Code register: load sets bits 8:1, step moves all nine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bif.code <= `LDC_RST_BIAS_CODE;
    end else if (ce) begin
      if (bif.load) begin
        if (bif.value > bif.limit)
          bif.code[8:1] <= bif.limit;
        else
          bif.code[8:1] <= bif.value;
      end else if (bif.step && !over) begin
        bif.code <= sum[8:0];
      end
    end
  end

  // Warning pulse on a rejected step or a clamped load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bif.warn <= 1'b0;
    end else if (ce) begin
      bif.warn <= (bif.step && over) ||
                  (bif.load && bif.value > bif.limit);
    end
  end
endmodule

`default_nettype wire

// ---- verilog/ldc_top.sv ----
// How it works
// - Laser-off input high or open turns off bias and modulation current.
// - Alarm output goes high on a hard fault and stays latched.
// - Alarm clears only when fault is gone and laser-off toggled.
// - Chip select rising starts a new serial access cycle.
// - Chip select low ends the cycle and idles the state machine.
// - Serial data is open-drain, bidirectional, with collision protection.
// - Polarity bit selects direct or inverted drive outputs.
// - Bit 3 of transmit control enables equalizer; setting from its register.
// - Readable status bit reports AC activity at the data input.
// - Bias current held as nine-bit code written over serial port.
// - Bias setting write loads only the upper eight code bits.
// - Code bit 0 clears at reset, changes only through step writes.
// - Bias limit caps the upper eight bits of the code.
// - Step register low five bits are signed step -16..+15.
// - Step overrunning the limit sets warning, code stays unchanged.
// - Hard fault alarms and disables drive; soft fault only warns.
// - Laser-off toggle also clears both fault status registers.
// - Reset keeps laser off and restores all control registers.
`timescale 1ns/1ps
`default_nettype none
`include "ldc_consts.svh"

module ldc_top #(
  parameter int ACT_WINDOW = `LDC_ACT_WINDOW
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              clk_en,
  input  wire logic              laser_off_in,
  input  wire logic              chip_select_input,
  input  wire logic              serial_clk_in,
  input  wire logic              serial_data_in,
  output var  logic              serial_data_out,
  output var  logic              serial_data_oe,
  input  wire logic              hard_fault_in,
  input  wire logic              soft_fault_in,
  input  wire logic              data_input_true,
  input  wire logic              data_input_inverted,
  output var  logic              drive_output_true,
  output var  logic              drive_output_inverted,
  output var  logic              bias_enable,
  output var  logic              mod_enable,
  output var  ldc_pkg::ldc_code_type bias_code,
  output var  logic              equalizer_enable,
  output var  ldc_pkg::ldc_byte_type equalizer_setting,
  output var  logic              alarm_out
);
  import ldc_pkg::*;

  localparam int AW = $clog2(ACT_WINDOW + 1);

  logic          rst_meta_q;
  logic          rst_n_q;
  logic [7:0]    pins_s;
  logic          off_s;
  logic          cs_s;
  logic          scl_s;
  logic          sda_s;
  logic          hard_s;
  logic          soft_s;
  logic          din_s;
  logic          dinn_s;
  logic          scl_prev_q;
  logic          off_prev_q;
  logic          din_prev_q;
  logic          scl_rise;
  logic          scl_fall;
  logic          off_toggle;
  ldc_state_type state_q;
  logic [3:0]    bits_q;
  logic [7:0]    head_q;
  logic [7:0]    shift_q;
  logic [7:0]    rdata_q;
  logic          collision_q;
  logic          wr_stb_q;
  ldc_addr_type  wr_addr_q;
  ldc_byte_type  wr_data_q;
  ldc_byte_type  tx_control_q;
  ldc_byte_type  eq_setting_q;
  ldc_byte_type  bias_limit_q;
  ldc_byte_type  bias_step_q;
  ldc_byte_type  fault_a_q;
  ldc_byte_type  fault_b_q;
  logic          alarm_q;
  logic          activity_q;
  logic [AW-1:0] act_cnt_q;
  logic          laser_on;

  ldc_bias_if bif ();

  // Read decode, used for the read frame and for status
  function automatic ldc_byte_type reg_read(input ldc_addr_type a);
    unique case (a)
      `LDC_OFF_TX_CONTROL:   reg_read = tx_control_q;
      `LDC_OFF_FAULT_A:      reg_read = fault_a_q;
      `LDC_OFF_FAULT_B:      reg_read = fault_b_q;
      `LDC_OFF_EQ_SETTING:   reg_read = eq_setting_q;
      `LDC_OFF_BIAS_SETTING: reg_read = bif.code[8:1];
      `LDC_OFF_BIAS_LIMIT:   reg_read = bias_limit_q;
      `LDC_OFF_BIAS_STEP:    reg_read = bias_step_q;
      `LDC_OFF_STATUS:       reg_read = {4'h0, collision_q, alarm_q,
                                         fault_b_q[`LDC_FB_BIAS_WARN], activity_q};
      default:               reg_read = 8'h00;
    endcase
  endfunction

  // Write-address match, used by every writable register
  function automatic logic wr_hit(input ldc_addr_type a);
    wr_hit = wr_stb_q && (wr_addr_q == a);
  endfunction

  // Reset release through two flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Pin synchronisers; laser-off starts high so the laser stays off
  ldc_sync #(
    .W    (8),
    .INIT (8'h01)
  ) u_sync (
    .clk   (mclk),
    .rst_n (rst_n_q),
    .ce    (clk_en),
    .d     ({data_input_inverted, data_input_true, soft_fault_in, hard_fault_in,
             serial_data_in, serial_clk_in, chip_select_input, laser_off_in}),
    .q     (pins_s)
  );

  assign {dinn_s, din_s, soft_s, hard_s, sda_s, scl_s, cs_s, off_s} = pins_s;

  ldc_bias u_bias (
    .clk   (mclk),
    .rst_n (rst_n_q),
    .ce    (clk_en),
    .bif   (bif)
  );

  // Edge history of the sampled serial clock, laser-off and data input
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_prev_q <= 1'b0;
      off_prev_q <= 1'b1;
      din_prev_q <= 1'b0;
    end else if (clk_en) begin
      scl_prev_q <= scl_s;
      off_prev_q <= off_s;
      din_prev_q <= din_s;
    end
  end

  assign scl_rise   = scl_s && !scl_prev_q;
  assign scl_fall   = !scl_s && scl_prev_q;
  assign off_toggle = !off_s && off_prev_q; // Toggle completes on return low

  // Serial frame engine: 1 read flag + 7 address bits, then 8 data bits
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= LDC_IDLE;
      bits_q  <= 4'h0;
      head_q  <= 8'h00;
      shift_q <= 8'h00;
    end else if (clk_en) begin
      if (!cs_s) begin
        state_q <= LDC_IDLE;
        bits_q  <= 4'h0;
      end else begin
        unique case (state_q)
          LDC_IDLE: begin
            state_q <= LDC_HEAD;
            bits_q  <= 4'h0;
          end
          LDC_HEAD: begin
            if (scl_rise) begin
              head_q <= {head_q[6:0], sda_s};
              if (bits_q == `LDC_HEAD_BITS - 4'h1) begin
                state_q <= LDC_DATA;
                bits_q  <= 4'h0;
              end else begin
                bits_q <= bits_q + 4'h1;
              end
            end
          end
          LDC_DATA: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              if (bits_q == `LDC_DATA_BITS - 4'h1) begin
                state_q <= LDC_DONE;
              end else begin
                bits_q <= bits_q + 4'h1;
              end
            end
          end
          LDC_DONE: begin
            state_q <= LDC_DONE; // Extra clocks ignored until select drops
          end
        endcase
      end
    end
  end

  // Write commit once the last data bit lands inside the select cycle
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_stb_q  <= 1'b0;
      wr_addr_q <= 7'h00;
      wr_data_q <= 8'h00;
    end else if (clk_en) begin
      wr_stb_q <= cs_s && state_q == LDC_DATA && scl_rise && !head_q[7] &&
                  bits_q == `LDC_DATA_BITS - 4'h1;
      wr_addr_q <= head_q[6:0];
      wr_data_q <= {shift_q[6:0], sda_s};
    end
  end

  // Read data: loaded at the end of the head, shifted on each data-bit falling clock except the last one (state is LDC_DONE by then);
  // the fall that closes the head is skipped so the MSB stands for the first data bit
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      if (state_q == LDC_HEAD && scl_rise && bits_q == `LDC_HEAD_BITS - 4'h1)
        rdata_q <= reg_read({head_q[5:0], sda_s});
      else if (state_q == LDC_DATA && scl_fall && bits_q != 4'h0)
        rdata_q <= {rdata_q[6:0], 1'b0};
    end
  end

  // Collision guard: released line read back low stops driving for the frame
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      collision_q <= 1'b0;
    end else if (clk_en) begin
      if (state_q == LDC_IDLE)
        collision_q <= 1'b0;
      else if (state_q == LDC_DATA && head_q[7] && scl_rise && serial_data_out && !sda_s)
        collision_q <= 1'b1;
    end
  end

  // Open-drain data pin: only ever pulls low, released for a one;
  // the last bit stands until select drops so the host can sample it
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      serial_data_out <= 1'b1;
      serial_data_oe  <= 1'b0;
    end else if (clk_en) begin
      serial_data_out <= 1'b1;
      serial_data_oe  <= 1'b0;
      if (cs_s && (state_q == LDC_DATA || state_q == LDC_DONE) && head_q[7] &&
          !collision_q) begin
        serial_data_out <= rdata_q[7];
        serial_data_oe  <= !rdata_q[7];
      end
    end
  end

  // Control registers written by complete frames
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_control_q <= `LDC_RST_TX_CONTROL;
      eq_setting_q <= `LDC_RST_EQ_SETTING;
      bias_limit_q <= `LDC_RST_BIAS_LIMIT;
      bias_step_q  <= `LDC_RST_BIAS_STEP;
    end else if (clk_en) begin
      if (wr_hit(`LDC_OFF_TX_CONTROL))
        tx_control_q <= wr_data_q;
      if (wr_hit(`LDC_OFF_EQ_SETTING))
        eq_setting_q <= wr_data_q;
      if (wr_hit(`LDC_OFF_BIAS_LIMIT))
        bias_limit_q <= wr_data_q;
      if (wr_hit(`LDC_OFF_BIAS_STEP))
        bias_step_q <= wr_data_q;
    end
  end

  // Bias requests to the code unit
  always_comb begin
    bif.load  = wr_hit(`LDC_OFF_BIAS_SETTING);
    bif.step  = wr_hit(`LDC_OFF_BIAS_STEP);
    bif.value = wr_data_q;
    bif.limit = bias_limit_q;
  end

  // Fault status: hard faults in A, soft faults and bias warning in B
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fault_a_q <= 8'h00;
      fault_b_q <= 8'h00;
    end else if (clk_en) begin
      if (off_toggle) begin
        fault_a_q <= 8'h00;
        fault_b_q <= 8'h00;
      end
      if (hard_s)
        fault_a_q[`LDC_FA_HARD] <= 1'b1;
      if (soft_s)
        fault_b_q[`LDC_FB_SOFT] <= 1'b1;
      if (bif.warn)
        fault_b_q[`LDC_FB_BIAS_WARN] <= 1'b1;
    end
  end

  // Alarm latch: set by a hard fault, cleared by a toggle once it has gone
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      alarm_q <= 1'b0;
    end else if (clk_en) begin
      if (hard_s)
        alarm_q <= 1'b1;
      else if (off_toggle)
        alarm_q <= 1'b0;
    end
  end

  assign laser_on = !off_s && !alarm_q && !hard_s;

  // Input activity: any edge on the true data leg (din_s) within the window
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      act_cnt_q  <= '0;
      activity_q <= 1'b0;
    end else if (clk_en) begin
      if (din_s != din_prev_q) begin
        act_cnt_q  <= AW'(ACT_WINDOW);
        activity_q <= 1'b1;
      end else if (act_cnt_q != '0) begin
        act_cnt_q <= act_cnt_q - AW'(1);
      end else begin
        activity_q <= 1'b0;
      end
    end
  end

  // Laser enables and alarm pin, off during reset
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bias_enable <= 1'b0;
      mod_enable  <= 1'b0;
      alarm_out   <= 1'b0;
    end else if (clk_en) begin
      bias_enable <= laser_on;
      mod_enable  <= laser_on;
      alarm_out   <= alarm_q || hard_s;
    end
  end

  // Drive outputs follow the data input, direct or inverted
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      drive_output_true     <= 1'b0;
      drive_output_inverted <= 1'b0;
    end else if (clk_en) begin
      if (!laser_on) begin
        drive_output_true     <= 1'b0;
        drive_output_inverted <= 1'b0;
      end else if (tx_control_q[`LDC_TXC_POL]) begin
        drive_output_true     <= dinn_s;
        drive_output_inverted <= din_s;
      end else begin
        drive_output_true     <= din_s;
        drive_output_inverted <= dinn_s;
      end
    end
  end

  // Code and equalizer outputs
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bias_code         <= `LDC_RST_BIAS_CODE;
      equalizer_enable  <= 1'b0;
      equalizer_setting <= `LDC_RST_EQ_SETTING;
    end else if (clk_en) begin
      bias_code         <= bif.code;
      equalizer_enable  <= tx_control_q[`LDC_TXC_EQ_EN];
      equalizer_setting <= eq_setting_q;
    end
  end
endmodule

`default_nettype wire

// ---- tb/ldc_props.sv ----
`timescale 1ns/1ps
`default_nettype none

// Port-level checks on the laser bias control block
module ldc_props #(
  parameter int ACT_WINDOW = 256
) (
  input wire logic                  mclk,
  input wire logic                  resetn,
  input wire logic                  laser_off_in,
  input wire logic                  chip_select_input,
  input wire logic                  hard_fault_in,
  input wire logic                  serial_data_out,
  input wire logic                  serial_data_oe,
  input wire logic                  bias_enable,
  input wire logic                  mod_enable,
  input wire logic                  drive_output_true,
  input wire logic                  drive_output_inverted,
  input wire ldc_pkg::ldc_code_type bias_code,
  input wire logic                  equalizer_enable,
  input wire ldc_pkg::ldc_byte_type equalizer_setting,
  input wire logic                  alarm_out
);
  import ldc_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // Cycles since the laser-off pin was last high, saturating
  logic [3:0] off_age_q;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      off_age_q <= 4'hf;
    end else if (laser_off_in) begin
      off_age_q <= 4'h0;
    end else if (off_age_q != 4'hf) begin
      off_age_q <= off_age_q + 4'h1;
    end
  end

  a_laser_off_dark: assert property (laser_off_in [*4] |->
    !bias_enable && !mod_enable && !drive_output_true && !drive_output_inverted)
    else $error("laser still driven while off");
  a_hard_fault_alarm: assert property (hard_fault_in [*4] |-> alarm_out && !bias_enable)
    else $error("hard fault not alarmed");
  a_alarm_clear_toggle: assert property ($fell(alarm_out) |-> off_age_q < 4'h9)
    else $error("alarm cleared without toggle");
  a_soft_keeps_on: assert property ((!laser_off_in && !hard_fault_in && !alarm_out) [*8] |->
    bias_enable && mod_enable)
    else $error("laser off without cause");
  a_cs_low_release: assert property (!chip_select_input [*4] |-> !serial_data_oe)
    else $error("data line driven outside frame");
  a_open_drain_only: assert property (serial_data_oe |-> !serial_data_out)
    else $error("data line driven high");
  a_bias_framed: assert property ($changed(bias_code) |-> $past(chip_select_input, 4))
    else $error("bias code changed outside frame");
  a_eq_framed: assert property ($changed(equalizer_setting) || $changed(equalizer_enable)
    |-> $past(chip_select_input, 4))
    else $error("equalizer changed outside frame");
endmodule

`default_nettype wire

// ---- tb/ldc_host.sv ----
`timescale 1ns/1ps
`default_nettype none

// Host on the three-wire port; sda high means released
module ldc_host (
  input  wire logic mclk,
  input  wire logic line,
  output var  logic cs,
  output var  logic scl,
  output var  logic sda
);
  initial begin
    cs = 1'b0;
    scl = 1'b0;
    sda = 1'b1;
  end

  // Half a serial clock period, inputs move just after the edge
  task automatic half();
    repeat (4) @(posedge mclk);
    #2;
  endtask

  // Frame of n bits; on a read sda is released except while bit cb pulls low
  task automatic xfer(input logic [15:0] f, input int n, input int cb, output logic [7:0] rd);
    rd = 8'h00;
    cs = 1'b1;
    half();
    for (int i = 15; i >= 16 - n; i--) begin
      sda = (f[15] && i < 8) ? (i != cb) : f[i];
      half();
      scl = 1'b1;
      half();
      if (i < 8) rd[i] = line;
      scl = 1'b0;
    end
    half();
    cs = 1'b0;
    sda = 1'b1;
    repeat (30) @(posedge mclk);
    #2;
  endtask
endmodule

`default_nettype wire

// ---- tb/ldc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; $display("[ERR] %0t mismatch got %h exp %h", $time, a, b); end end

module ldc_top_tb;
  import ldc_pkg::*;
  logic         mclk = 1'b0;
  logic         resetn = 1'b0;
  logic         laser_off_in = 1'b1;
  logic         hard_fault_in = 1'b0;
  logic         soft_fault_in = 1'b0;
  logic         din = 1'b0;
  logic         act_on = 1'b0;
  logic         ce = 1'b1;
  logic         cs, scl, sda, line, sdo, sdoe, drv_t, drv_n, bias_en, mod_en, eq_en, alarm;
  ldc_code_type bias_code;
  ldc_byte_type eq_set, r, lim;
  logic [31:0]  seed = 32'd82;
  int           fail_count = 0;
  int           num_checks = 0;
  int           cyc = 0;

  always #10 mclk = ~mclk;
  // Pull-up resolves the released data line
  assign line = sda & (sdo | ~sdoe);

  ldc_top #(.ACT_WINDOW(16)) ldc_top_inst (
    .mclk(mclk), .resetn(resetn), .clk_en(ce), .laser_off_in(laser_off_in),
    .chip_select_input(cs), .serial_clk_in(scl), .serial_data_in(line),
    .serial_data_out(sdo), .serial_data_oe(sdoe), .hard_fault_in(hard_fault_in),
    .soft_fault_in(soft_fault_in), .data_input_true(din), .data_input_inverted(~din),
    .drive_output_true(drv_t), .drive_output_inverted(drv_n), .bias_enable(bias_en),
    .mod_enable(mod_en), .bias_code(bias_code), .equalizer_enable(eq_en),
    .equalizer_setting(eq_set), .alarm_out(alarm)
  );
  ldc_host ldc_host_inst (.mclk(mclk), .line(line), .cs(cs), .scl(scl), .sda(sda));

  // Data activity and hang guard
  always @(posedge mclk) begin
    if (act_on) #2 din = ~din;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
    ldc_host_inst.xfer({1'b0, a, d}, n, -1, r);
  endtask
  task automatic rd(input logic [6:0] a, input int cb = -1);
    ldc_host_inst.xfer({1'b1, a, 8'h00}, 16, cb, r);
  endtask
  task automatic toggle_off();
    laser_off_in = 1'b1;
    tick(10);
    laser_off_in = 1'b0;
    tick(10);
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    int code;
    int sum;
    logic [4:0] s;
    tick(12);
    resetn = 1'b1;
    tick(10);
    // Defaults, unmapped place included, read as zero
    for (int a = 0; a < 9; a++) begin
      rd(7'(a));
      `CHK(r, 8'h00)
    end
    `CHK({bias_code, bias_en}, 10'h000)
    laser_off_in = 1'b0;
    tick(10);
    `CHK({bias_en, mod_en}, 2'b11)
    // Load at the limit, then signed steps with rejections
    lim = 8'h20 + 8'(xs() % 32'd192);
    wr(7'h05, lim);
    wr(7'h04, lim);
    code = {lim, 1'b0};
    `CHK(bias_code, 9'(code))
    for (int i = 0; i < 20; i++) begin
      s = (i < 2) ? 5'h01 : 5'(xs());
      if (i == 10) begin
        wr(7'h04, 8'h00);
        code = code % 2; // Load leaves bit 0 alone
        s = 5'h1f;
      end
      sum = code + int'($signed(s));
      if (sum >= 0 && sum <= 2 * lim + 1) code = sum;
      wr(7'h06, {3'(xs()), s});
      `CHK(bias_code, 9'(code))
    end
    rd(7'h07);
    `CHK(r[1], 1'b1)
    wr(7'h04, 8'hff);
    `CHK(bias_code[8:1], lim)
    // Aborted frame, equalizer, polarity and collision
    wr(7'h03, 8'h5a, 12);
    `CHK(eq_set, 8'h00)
    wr(7'h03, 8'h5a);
    `CHK(eq_set, 8'h5a)
    wr(7'h00, 8'h0a);
    din = 1'b1;
    tick(6);
    `CHK({eq_en, drv_t, drv_n}, 3'b101)
    rd(7'h00, 3);
    `CHK(r, 8'h07)
    rd(7'h00);
    `CHK(r, 8'h0a)
    wr(7'h00, 8'h00);
    tick(6);
    `CHK({eq_en, drv_t, drv_n}, 3'b010)
    // Clock enable low freezes the drive path, release lets it follow again
    ce = 1'b0;
    din = 1'b0;
    tick(6);
    `CHK(drv_t, 1'b1)
    ce = 1'b1;
    tick(6);
    `CHK(drv_t, 1'b0)
    // Input activity seen, then expired
    act_on = 1'b1;
    rd(7'h07);
    `CHK(r[0], 1'b1)
    act_on = 1'b0;
    tick(40);
    rd(7'h07);
    `CHK(r[0], 1'b0)
    // Hard fault latch, toggle while present, soft fault
    hard_fault_in = 1'b1;
    tick(10);
    `CHK({alarm, bias_en, mod_en}, 3'b100)
    toggle_off();
    `CHK(alarm, 1'b1)
    hard_fault_in = 1'b0;
    tick(10);
    `CHK(alarm, 1'b1)
    rd(7'h01);
    `CHK(r[0], 1'b1)
    toggle_off();
    `CHK({alarm, bias_en}, 2'b01)
    soft_fault_in = 1'b1;
    tick(10);
    rd(7'h02);
    `CHK({r[0], bias_en, alarm}, 3'b110)
    soft_fault_in = 1'b0;
    toggle_off();
    rd(7'h01);
    `CHK(r, 8'h00)
    rd(7'h02);
    `CHK(r, 8'h00)
    wrap_up();
  end
endmodule

bind ldc_top ldc_props #(.ACT_WINDOW(ACT_WINDOW)) ldc_props_inst (
  .mclk(mclk), .resetn(resetn), .laser_off_in(laser_off_in),
  .chip_select_input(chip_select_input), .hard_fault_in(hard_fault_in),
  .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
  .bias_enable(bias_enable), .mod_enable(mod_enable),
  .drive_output_true(drive_output_true), .drive_output_inverted(drive_output_inverted),
  .bias_code(bias_code), .equalizer_enable(equalizer_enable),
  .equalizer_setting(equalizer_setting), .alarm_out(alarm_out)
);

`default_nettype wire
